// file: rtl/counter_slice.sv
// one 32-bit event counter with carry-out chain pulse
`timescale 1ns/1ps
module counter_slice
  import pmon_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             wr_en,
  input  wire logic [CTR_W-1:0] wr_data,
  input  wire logic             inc,
  output logic      [CTR_W-1:0] count_q,
  output logic                  chain_q
);
  logic [CTR_W-1:0] count_d;

  // a software write wins over a same-cycle increment
  always_comb
  begin
    count_d = count_q;
    if (wr_en)
      count_d = wr_data;
    else if (inc)
      count_d = count_q + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_q <= RESET_WORD;
    else
      count_q <= count_d;
  end

  // msb falling is the carry-out seen by chained counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chain_q <= 1'b0;
    else
      chain_q <= count_q[CTR_W-1] & ~count_d[CTR_W-1];
  end

  a_chain_on_fall: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(count_q[CTR_W-1]) |-> chain_q)
    else $error("chain pulse missing after msb fell");
endmodule

// file: rtl/pmon_pkg.sv
// shared constants, field layouts and carrier types of the event counter monitor
package pmon_pkg;
  localparam int          NUM_CTR      = 16;       // counters actually built
  localparam int          CTR_W        = 32;
  localparam int          IDX_W        = 4;
  localparam int          NUM_W        = 10;       // monitor register number width
  localparam int          ADDR_LSB     = 2;        // byte address = number * 4
  localparam int          SUP_BIT      = 4;        // bit 5 counted from the msb of the number
  localparam int          GRP_LSB      = 7;
  localparam int          GRP_W        = 3;
  localparam logic [2:0]  GRP_CTR      = 3'h0;
  localparam logic [2:0]  GRP_LCA      = 3'h1;
  localparam logic [2:0]  GRP_LCB      = 3'h2;
  localparam logic [2:0]  GRP_GLB      = 3'h3;
  localparam logic [2:0]  GRP_VEC      = 3'h4;
  localparam logic [1:0]  PAD_ZERO     = 2'h0;     // number bits 6:5 must be zero
  // local_control_a fields
  localparam int          LA_FTC       = 31;       // freeze_this_counter
  localparam int          LA_FSUP      = 29;       // freeze_when_supervisor
  localparam int          LA_FUSR      = 28;       // freeze_when_user
  localparam int          LA_FMRK      = 27;       // freeze_when_marked
  localparam int          LA_FUNM      = 26;       // freeze_when_unmarked
  localparam int          LA_WDE       = 25;       // wrap_detect_enable
  localparam int          LA_FGST      = 24;       // freeze_in_guest
  localparam int          LA_FHYP      = 23;       // freeze_in_hypervisor
  localparam int          LA_EVT_LSB   = 16;
  localparam int          EVT_W        = 5;        // msb selects a chain source
  // global_monitor_control fields
  localparam int          GC_FEC       = 31;       // freeze_every_counter
  localparam int          GC_MIE       = 30;       // monitor_interrupt_enable
  localparam int          GC_FOEC      = 29;       // freeze_on_enabled_condition
  localparam logic [31:0] LCA_MASK     = 32'hbf9f_0000;
  localparam logic [31:0] GLB_MASK     = 32'he000_0000;
  localparam logic [31:0] VEC_MASK     = 32'h0000_fff0;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  localparam logic [15:0] MARK_BLIND   = 16'h0001; // events counted whatever the mark

  typedef struct packed {
    logic user_state_bit;
    logic process_mark_bit;
    logic guest_state_bit;
    logic external_interrupt_enable;
    logic monitor_guest_protect;
    logic monitor_enable_bit;
  } core_state_t;

  typedef enum logic [2:0] {TGT_NONE, TGT_CTR, TGT_LCA, TGT_LCB, TGT_GLB, TGT_VEC} target_t;

  typedef struct packed {
    target_t          target;
    logic [IDX_W-1:0] idx;
    logic             privilege_fault;
    logic             illegal_fault;
  } access_t;
endpackage

// file: rtl/pmr_decode.sv
// monitor register number decoder with privilege and legality checks
`timescale 1ns/1ps
module pmr_decode
  import pmon_pkg::*;
(
  input  wire logic [31:0] paddr,
  input  wire logic        write,
  input  wire core_state_t cs,
  output access_t          acc
);
  logic [NUM_W-1:0] num;
  logic [GRP_W-1:0] grp;
  logic             archd;

  assign num = paddr[ADDR_LSB +: NUM_W];
  assign grp = num[GRP_LSB +: GRP_W];

  // unbuilt counters fall through to the same path as unknown numbers
  always_comb
  begin
    acc        = '0;
    acc.idx    = num[IDX_W-1:0];
    acc.target = TGT_NONE;
    archd      = (num[SUP_BIT+2:SUP_BIT+1] == PAD_ZERO) && (paddr[1:0] == 2'h0)
                 && (paddr[31:ADDR_LSB+NUM_W] == '0);
    unique case (grp)
      GRP_CTR: if (int'(acc.idx) < NUM_CTR) acc.target = TGT_CTR;
      GRP_LCA: if (int'(acc.idx) < NUM_CTR) acc.target = TGT_LCA;
      GRP_LCB: if (int'(acc.idx) < NUM_CTR) acc.target = TGT_LCB;
      GRP_GLB: if (acc.idx == '0) acc.target = TGT_GLB;
      GRP_VEC: if (acc.idx == '0 && num[SUP_BIT]) acc.target = TGT_VEC;
      default: acc.target = TGT_NONE;
    endcase
    if (!archd)
      acc.target = TGT_NONE;
    if (acc.target == TGT_NONE)
      acc.illegal_fault = 1'b1;
    else if (!num[SUP_BIT] && write)
      acc.illegal_fault = 1'b1;                       // user numbers are read only
    else if (num[SUP_BIT] && cs.user_state_bit)
      acc.privilege_fault = 1'b1;                     // supervisor number from user
    else if (cs.guest_state_bit && cs.monitor_guest_protect)
      acc.privilege_fault = 1'b1;                     // guest locked out
    if (acc.illegal_fault || acc.privilege_fault)
      acc.target = TGT_NONE;
  end
endmodule

// file: rtl/processor_event_counter_monitor.sv
// event counter monitor: counters, local and global controls, apb access, exception
// Notes on behaviour
// - sixteen 32-bit counters, fewer allowed
// - user and supervisor numbers share one register
// - number bit five selects user or supervisor
// - supervisor number from user mode faults
// - any write to user number is illegal
// - unbuilt counters act as unknown numbers
// - local controls n govern counter n only
// - global control acts on all counters
// - guest protect bit blocks guest access
// - exception when wrap enabled, flagged, enabled
// - enabled overflow condition freezes every counter
// - interrupt taken only at top priority
// - exception is a level, drops at once
// - counting follows user and mark filter state
// - filter bits freeze their named states
// - some events ignore the mark, fixed
// - vector comes from the vector offset register
// - global and local freeze stop unconditionally
// - msb one to zero yields chain event
`timescale 1ns/1ps
module processor_event_counter_monitor
  import pmon_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire core_state_t        core_state,
  input  wire logic [NUM_CTR-1:0] event_in,
  input  wire logic               higher_pending,
  output logic                    monitor_exception,
  output logic                    interrupt_take,
  output logic      [31:0]        interrupt_vector,
  output logic                    frozen_all,
  output logic                    privilege_fault,
  output logic                    illegal_fault
);
  logic [CTR_W-1:0]   count    [NUM_CTR];
  logic [31:0]        lca_q    [NUM_CTR];
  logic [31:0]        lcb_q    [NUM_CTR];
  logic [31:0]        glb_q;
  logic [31:0]        vec_q;
  logic [31:0]        prdata_q;
  logic               err_q;
  logic               priv_q;
  logic               ill_q;
  logic [NUM_CTR-1:0] chain;
  logic [NUM_CTR-1:0] inc;
  logic [NUM_CTR-1:0] ctr_wr;
  logic [NUM_CTR-1:0] wrap_cond;
  logic               setup;
  logic               access;
  logic               wr_ok;
  logic [31:0]        merged;
  access_t            acc;

  // byte lanes of a write merged onto the old word
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[8*b +: 8] = new_w[8*b +: 8];
    end
    return res;
  endfunction

  // true when the current core state is left unfrozen by a local control word
  function automatic logic state_open(input logic [31:0] lca, input core_state_t cs,
                                      input logic blind);
    logic open_q;
    open_q = 1'b1;
    if (lca[LA_FSUP] && !cs.user_state_bit)
      open_q = 1'b0;
    if (lca[LA_FUSR] && cs.user_state_bit)
      open_q = 1'b0;
    if (!blind && lca[LA_FMRK] && cs.process_mark_bit)
      open_q = 1'b0;
    if (!blind && lca[LA_FUNM] && !cs.process_mark_bit)
      open_q = 1'b0;
    if (lca[LA_FGST] && cs.guest_state_bit)
      open_q = 1'b0;
    if (lca[LA_FHYP] && !cs.guest_state_bit)
      open_q = 1'b0;
    return open_q;
  endfunction

  pmr_decode u_decode (
    .paddr (paddr),
    .write (pwrite),
    .cs    (core_state),
    .acc   (acc)
  );

  // apb phases; the slave never stretches a transfer
  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign wr_ok  = access & pwrite & ~err_q;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = err_q & access;

  // the word under the current number, used for the read data
  always_comb
  begin
    merged = RESET_WORD;
    unique case (acc.target)
      TGT_CTR:  merged = count[acc.idx];
      TGT_LCA:  merged = lca_q[acc.idx];
      TGT_LCB:  merged = lcb_q[acc.idx];
      TGT_GLB:  merged = glb_q;
      TGT_VEC:  merged = vec_q;
      TGT_NONE: merged = RESET_WORD;
    endcase
  end

  // read data and the error are latched in setup so they come from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= RESET_WORD;
      err_q    <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q <= (pwrite || acc.target == TGT_NONE) ? RESET_WORD : merged;
      err_q    <= acc.illegal_fault | acc.privilege_fault;
    end
  end

  // fault pulses last one cycle after the completing edge of a refused access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      priv_q <= 1'b0;
      ill_q  <= 1'b0;
    end
    else
    begin
      priv_q <= access & acc.privilege_fault;
      ill_q  <= access & acc.illegal_fault;
    end
  end
  assign privilege_fault = priv_q;
  assign illegal_fault   = ill_q;

  // local control registers, one pair per counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_CTR; i++)
      begin
        lca_q[i] <= RESET_WORD;
        lcb_q[i] <= RESET_WORD;
      end
    end
    else if (wr_ok)
    begin
      if (acc.target == TGT_LCA)
        lca_q[acc.idx] <= merge(lca_q[acc.idx], pwdata, pstrb) & LCA_MASK;
      if (acc.target == TGT_LCB)
        lcb_q[acc.idx] <= merge(lcb_q[acc.idx], pwdata, pstrb);
    end
  end

  // global control and vector offset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      glb_q <= RESET_WORD;
      vec_q <= RESET_WORD;
    end
    else if (wr_ok)
    begin
      if (acc.target == TGT_GLB)
        glb_q <= merge(glb_q, pwdata, pstrb) & GLB_MASK;
      if (acc.target == TGT_VEC)
        vec_q <= merge(vec_q, pwdata, pstrb) & VEC_MASK;
    end
  end

  // overflow condition per counter; wrap flag is the counter msb
  always_comb
  begin
    for (int i = 0; i < NUM_CTR; i++)
      wrap_cond[i] = lca_q[i][LA_WDE] & count[i][CTR_W-1];
  end

  // freeze on enabled condition holds even with the interrupt masked by ee
  assign frozen_all = glb_q[GC_FEC]
                    | (glb_q[GC_MIE] & glb_q[GC_FOEC] & (|wrap_cond));

  // purely combinational so it drops the cycle any term fails
  assign monitor_exception = (|wrap_cond) & glb_q[GC_MIE]
                           & (core_state.external_interrupt_enable | core_state.guest_state_bit);
  assign interrupt_take    = monitor_exception & ~higher_pending;
  assign interrupt_vector  = vec_q;

  // counter slices: event select, filters and freezes per index
  for (genvar n = 0; n < NUM_CTR; n++)
  begin : g_ctr
    logic [EVT_W-1:0] sel;
    logic             evt;
    logic             blind;

    assign sel   = lca_q[n][LA_EVT_LSB +: EVT_W];
    // upper half of the select space picks another counter's carry-out
    assign evt   = sel[EVT_W-1] ? chain[sel[IDX_W-1:0]] : event_in[sel[IDX_W-1:0]];
    assign blind = ~sel[EVT_W-1] & MARK_BLIND[sel[IDX_W-1:0]];
    assign inc[n] = evt & core_state.monitor_enable_bit & ~frozen_all
                  & ~lca_q[n][LA_FTC]
                  & state_open(lca_q[n], core_state, blind);
    assign ctr_wr[n] = wr_ok & (acc.target == TGT_CTR) & (acc.idx == IDX_W'(n));

    counter_slice u_slice (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (ctr_wr[n]),
      .wr_data (merge(count[n], pwdata, pstrb)),
      .inc     (inc[n]),
      .count_q (count[n]),
      .chain_q (chain[n])
    );

    a_user_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      (core_state.user_state_bit && lca_q[n][LA_FUSR] && !ctr_wr[n])
        |=> count[n] == $past(count[n]))
      else $error("counter moved in a frozen user state");

    // each other filter and freeze holds the count while its state is shut out
    a_supv_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      (!core_state.user_state_bit && lca_q[n][LA_FSUP] && !ctr_wr[n])
        |=> count[n] == $past(count[n]))
      else $error("counter moved in a frozen supervisor state");

    a_mark_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      (core_state.process_mark_bit && lca_q[n][LA_FMRK] && !blind && !ctr_wr[n])
        |=> count[n] == $past(count[n]))
      else $error("counter moved in a frozen marked state");

    a_unmark_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      (!core_state.process_mark_bit && lca_q[n][LA_FUNM] && !blind && !ctr_wr[n])
        |=> count[n] == $past(count[n]))
      else $error("counter moved in a frozen unmarked state");

    a_guest_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      (core_state.guest_state_bit && lca_q[n][LA_FGST] && !ctr_wr[n])
        |=> count[n] == $past(count[n]))
      else $error("counter moved in a frozen guest state");

    a_hyp_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      (!core_state.guest_state_bit && lca_q[n][LA_FHYP] && !ctr_wr[n])
        |=> count[n] == $past(count[n]))
      else $error("counter moved in a frozen hypervisor state");

    a_local_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      (lca_q[n][LA_FTC] && !ctr_wr[n])
        |=> count[n] == $past(count[n]))
      else $error("counter moved under its own freeze");

    a_enable_off: assert property (@(posedge pclk) disable iff (!presetn)
      (!core_state.monitor_enable_bit && !ctr_wr[n])
        |=> count[n] == $past(count[n]))
      else $error("counter moved with monitoring disabled");
  end

  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    (inc[0] && !ctr_wr[0]) |=> count[0] == $past(count[0]) + 32'h0000_0001)
    else $error("counter did not advance by one");

  a_freeze_every: assert property (@(posedge pclk) disable iff (!presetn)
    (glb_q[GC_FEC] && !wr_ok) |=> (count[0] == $past(count[0])) && (count[1] == $past(count[1])))
    else $error("counter moved under global freeze");

  a_freeze_overflow: assert property (@(posedge pclk) disable iff (!presetn)
    (glb_q[GC_MIE] && glb_q[GC_FOEC] && wrap_cond[5]) |-> frozen_all && !inc[1])
    else $error("enabled overflow did not freeze counters");

  a_exc_drops: assert property (@(posedge pclk) disable iff (!presetn)
    (!glb_q[GC_MIE] || !(core_state.external_interrupt_enable || core_state.guest_state_bit))
      |-> !monitor_exception)
    else $error("exception held with an enable missing");

  a_exc_raises: assert property (@(posedge pclk) disable iff (!presetn)
    (lca_q[5][LA_WDE] && count[5][CTR_W-1] && glb_q[GC_MIE]
      && core_state.external_interrupt_enable) |-> monitor_exception)
    else $error("exception missing for enabled wrap");

  a_take_priority: assert property (@(posedge pclk) disable iff (!presetn)
    interrupt_take |-> monitor_exception && !higher_pending && interrupt_vector == vec_q)
    else $error("interrupt taken while outranked");

  a_user_write: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && pwrite && !paddr[ADDR_LSB+SUP_BIT]) |=> pslverr ##1 illegal_fault)
    else $error("write to user number not refused");

  a_priv_check: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr[ADDR_LSB+SUP_BIT] && core_state.user_state_bit)
      |=> pslverr && prdata == RESET_WORD)
    else $error("supervisor read from user not refused");

  // refused or misdirected accesses leave other registers as they were
  a_local_only: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && acc.target == TGT_LCA && acc.idx != '0)
      |=> lca_q[0] == $past(lca_q[0]))
    else $error("local control write reached another index");

  a_refused_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (access && err_q)
      |=> glb_q == $past(glb_q) && vec_q == $past(vec_q))
    else $error("refused access changed a register");

  a_fault_single: assert property (@(posedge pclk) disable iff (!presetn)
    illegal_fault |=> !illegal_fault)
    else $error("illegal fault longer than one cycle");

  a_write_rdzero: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && pwrite) |=> prdata == RESET_WORD)
    else $error("write returned read data");

  a_priv_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (access && acc.privilege_fault) |=> privilege_fault)
    else $error("privilege fault pulse missing");
endmodule

// file: testbench/tb_processor_event_counter_monitor.sv
// self-checking bench for the event counter monitor over apb
`timescale 1ns/1ps
module tb_processor_event_counter_monitor;
  import pmon_pkg::*;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [31:0]        paddr;
  logic [31:0]        pwdata;
  logic [3:0]         pstrb;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  core_state_t        core_state;
  logic [NUM_CTR-1:0] event_in;
  logic               higher_pending;
  logic               monitor_exception;
  logic               interrupt_take;
  logic [31:0]        interrupt_vector;
  logic               frozen_all;
  logic               privilege_fault;
  logic               illegal_fault;
  logic [31:0]        rdat;
  logic               err;
  logic               pf;
  logic               il;
  int                 n_errors;
  int                 compares;

  processor_event_counter_monitor dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_state(core_state), .event_in(event_in),
    .higher_pending(higher_pending), .monitor_exception(monitor_exception),
    .interrupt_take(interrupt_take), .interrupt_vector(interrupt_vector),
    .frozen_all(frozen_all), .privilege_fault(privilege_fault),
    .illegal_fault(illegal_fault));

  // free-running 250 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic end_of_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // byte address of a monitor register number
  function automatic logic [31:0] num(input int g, input int n);
    return 32'((g + n) * 4);
  endfunction

  // one apb transfer; request held until pready is seen at an edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
      k++;
    end
    chk("wait_states", 32'h0, 32'(k));
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
    pf = privilege_fault;
    il = illegal_fault;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk("pslverr", 32'h0, {31'h0, err});
    chk("read_data", e, rdat);
  endtask

  // refused access: error in access phase, one fault pulse just after
  task automatic flt(input logic w, input logic [31:0] a, input logic p, input logic i);
    bus(w, a, 32'hffff_ffff, 4'hf);
    chk("pslverr", 32'h1, {31'h0, err});
    chk("privilege_fault", {31'h0, p}, {31'h0, pf});
    chk("illegal_fault", {31'h0, i}, {31'h0, il});
  endtask

  // core state order: user, mark, guest, ext enable, guest protect, monitor enable
  task automatic setcs(input logic [5:0] v);
    @(posedge pclk);
    core_state <= core_state_t'(v);
    #1;
  endtask

  task automatic pulse(input int e, input int n);
    @(posedge pclk);
    event_in[e] <= 1'b1;
    repeat (n) @(posedge pclk);
    event_in[e] <= 1'b0;
    @(posedge pclk);
    #1;
  endtask

  task automatic t_reset();
    rdc(num(16, 0), 32'h0);
    rdc(num(144, 0), 32'h0);
    rdc(num(400, 0), 32'h0);
    chk("frozen_all", 32'h0, {31'h0, frozen_all});
    $display("test reset done");
  endtask

  task automatic t_access();
    setcs(6'b000001);
    wr(num(16, 3), 32'h1234_5678);
    rdc(num(0, 3), 32'h1234_5678);
    flt(1'b1, num(0, 3), 1'b0, 1'b1);
    rdc(num(16, 3), 32'h1234_5678);
    wr(num(272, 0), 32'h1122_3344);
    bus(1'b1, num(272, 0), 32'haabb_ccdd, 4'h2);
    rdc(num(272, 0), 32'h1122_cc44);
    wr(num(144, 0), 32'hffff_ffff);
    rdc(num(144, 0), LCA_MASK);
    wr(num(144, 0), 32'h0);
    flt(1'b0, num(700, 0), 1'b0, 1'b1);
    flt(1'b0, num(512, 0), 1'b0, 1'b1);
    setcs(6'b100001);
    flt(1'b0, num(16, 3), 1'b1, 1'b0);
    rdc(num(0, 3), 32'h1234_5678);
    flt(1'b1, num(0, 3), 1'b0, 1'b1);
    setcs(6'b001011);
    flt(1'b0, num(0, 3), 1'b1, 1'b0);
    setcs(6'b000001);
    $display("test access done");
  endtask

  // each filter bit against all eight user, mark and guest states
  task automatic t_filters();
    int   fb[6] = '{29, 28, 27, 26, 24, 23};
    logic fz;
    logic sl;
    for (int b = 0; b < 6; b++)
      for (int s = 0; s < 8; s++)
      begin
        sl = (b < 2) ? s[2] : (b < 4) ? s[1] : s[0];
        fz = sl ^ (b == 0 || b == 3 || b == 5);
        setcs(6'b000001);
        wr(num(144, 2), 32'h0002_0000 | (32'h1 << fb[b]));
        wr(num(16, 2), 32'h0);
        setcs({s[2:0], 3'b001});
        pulse(2, 3);
        setcs(6'b000001);
        rdc(num(16, 2), fz ? 32'h0 : 32'h3);
      end
    $display("test filters done");
  endtask

  task automatic t_freeze();
    wr(num(144, 2), 32'h8002_0000);
    wr(num(144, 3), 32'h0002_0000);
    wr(num(16, 2), 32'h0);
    wr(num(16, 3), 32'h0);
    pulse(2, 4);
    rdc(num(16, 2), 32'h0);
    rdc(num(16, 3), 32'h4);
    wr(num(400, 0), 32'h8000_0000);
    chk("frozen_all", 32'h1, {31'h0, frozen_all});
    pulse(2, 4);
    rdc(num(16, 3), 32'h4);
    setcs(6'b000000);
    pulse(2, 2);
    setcs(6'b000001);
    rdc(num(16, 3), 32'h4);
    wr(num(400, 0), 32'h0);
    wr(num(144, 4), 32'h0800_0000);
    wr(num(16, 4), 32'h0);
    setcs(6'b010001);
    pulse(0, 3);
    setcs(6'b000001);
    rdc(num(16, 4), 32'h3);
    $display("test freeze done");
  endtask

  task automatic t_exception();
    setcs(6'b000101);
    wr(num(16, 5), 32'h7fff_fffe);
    wr(num(144, 5), 32'h0205_0000);
    wr(num(400, 0), 32'h4000_0000);
    pulse(5, 1);
    chk("exception", 32'h0, {31'h0, monitor_exception});
    pulse(5, 1);
    chk("exception", 32'h1, {31'h0, monitor_exception});
    chk("take", 32'h1, {31'h0, interrupt_take});
    @(posedge pclk);
    higher_pending <= 1'b1;
    #1;
    chk("take", 32'h0, {31'h0, interrupt_take});
    @(posedge pclk);
    higher_pending <= 1'b0;
    setcs(6'b000001);
    chk("exception", 32'h0, {31'h0, monitor_exception});
    pulse(5, 1);
    rdc(num(16, 5), 32'h8000_0001);
    setcs(6'b001001);
    chk("exception", 32'h1, {31'h0, monitor_exception});
    setcs(6'b000001);
    wr(num(400, 0), 32'h6000_0000);
    chk("frozen_all", 32'h1, {31'h0, frozen_all});
    pulse(5, 2);
    rdc(num(16, 5), 32'h8000_0001);
    wr(num(16, 5), 32'h0);
    chk("frozen_all", 32'h0, {31'h0, frozen_all});
    wr(num(400, 0), 32'h0);
    wr(num(144, 5), 32'h0);
    $display("test exception done");
  endtask

  task automatic t_chain_vector();
    wr(num(144, 7), 32'h0007_0000);
    wr(num(144, 8), 32'h0017_0000);
    wr(num(16, 8), 32'h0);
    wr(num(16, 7), 32'hffff_ffff);
    pulse(7, 1);
    repeat (2) @(posedge pclk);
    rdc(num(16, 7), 32'h0);
    rdc(num(16, 8), 32'h1);
    wr(num(528, 0), 32'hdead_beef);
    chk("vector", 32'hdead_beef & VEC_MASK, interrupt_vector);
    rdc(num(528, 0), 32'hdead_beef & VEC_MASK);
    $display("test chain_vector done");
  endtask

  // watchdog well beyond the thousand or so cycles the tests need
  initial
  begin
    #200000;
    n_errors++;
    end_of_test();
  end

  initial
  begin
    n_errors       = 0;
    compares       = 0;
    presetn        = 1'b0;
    psel           = 1'b0;
    penable        = 1'b0;
    pwrite         = 1'b0;
    paddr          = 32'h0;
    pwdata         = 32'h0;
    pstrb          = 4'hf;
    core_state     = core_state_t'(6'b000001);
    event_in       = '0;
    higher_pending = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_access();
    t_filters();
    t_freeze();
    t_exception();
    t_chain_vector();
    end_of_test();
  end
endmodule
